// ===== verilog/selfprog_seq.sv
// module: flash self-programming sequencer top
// Operation
// - write durations count ticks of the calibrated oscillator, not cpu clock
// - erase, page write and lock write each last 3.7 to 4.5 ms
// - boot size code picks 4, 8, 16 or 32 pages at flash top
// - boot vector is first word of boot section; app ends just below
// - concurrent region is lowest 224 pages; top 32 pages are not
// - program counter 14 or 15 bits; pages of 64 or 128 words
// - page select comes from z-pointer bits above word field
// - z bits 6/7..1 select buffer word; zero for page write
// - z bit 0 is lpm byte select; zero for store commands
// - busy flag stays set until re-enable command with enable bit
// - during erase or write only no-concurrent region may be fetched
// - page write needs pattern then store within four cycles
// - write into no-concurrent region halts cpu for whole operation
// - busy flag holds while region busy; clears only on re-enable
`timescale 1ns/100ps
module selfprog_seq #(
   parameter bit LARGE   = 1'b0,
   parameter int TICK_HZ = 1000000
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_clk_en,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   input  wire logic        i_store_op,
   input  wire logic        i_load_op,
   input  wire logic [15:0] i_zptr,
   input  wire logic [14:0] i_fetch_addr,
   input  wire logic [1:0]  i_boot_size_sel,
   input  wire logic        i_eeprom_write_strobe,
   input  wire logic        i_osc_tick,
   output logic             o_cpu_halt,
   output logic             o_fetch_blocked,
   output logic             o_flash_erase,
   output logic             o_flash_write,
   output logic             o_lock_write,
   output logic             o_buf_load,
   output logic      [7:0]  o_page_sel,
   output logic      [6:0]  o_word_sel,
   output logic             o_byte_sel,
   output logic      [14:0] o_boot_vector,
   output logic             o_irq
);
   // ************************************************************
   // state
   // ************************************************************
   // variant widths
   localparam int PCW = LARGE ? selfprog_pkg::PC_BITS_LARGE : selfprog_pkg::PC_BITS_SMALL;

   typedef struct packed {
      selfprog_pkg::seq_state_t st;
      logic [5:0]  cmd;
      logic [2:0]  win;
      logic        busy;
      logic        halt;
      logic        erase;
      logic        write;
      logic        lockw;
      logic        bload;
      logic [selfprog_pkg::IRQ_WIDTH-1:0] sts;
      logic [selfprog_pkg::IRQ_WIDTH-1:0] msk;
      logic [7:0]  rdata;
      logic [7:0]  pg;
      logic [6:0]  wd;
      logic        bs;
   } seq_t;
   seq_t q, d;

   logic tmr_start;
   logic tmr_done;
   logic wr_ctrl;
   logic timed_cmd;

   selfprog_if #(.PCW(15)) mif ();

   selfprog_addr_map #(.LARGE(LARGE)) u_map (
      .i_boot_size_sel (i_boot_size_sel),
      .i_zptr          (i_zptr),
      .i_fetch_addr    (i_fetch_addr),
      .map             (mif.map)
   );

   selfprog_timer #(.TICK_HZ(TICK_HZ)) u_tmr (
      .i_ref_clk  (i_ref_clk),
      .i_reset_n  (i_reset_n),
      .i_clk_en   (i_clk_en),
      .i_osc_tick (i_osc_tick),
      .i_start    (tmr_start),
      .o_done     (tmr_done)
   );

   // ************************************************************
   // sequencer
   // ************************************************************
   // eeprom write blocks every control write
   assign wr_ctrl   = i_wr && (i_addr == selfprog_pkg::ADDR_CTRL) && !i_eeprom_write_strobe;
   assign timed_cmd = (q.cmd == selfprog_pkg::CMD_ERASE) || (q.cmd == selfprog_pkg::CMD_WRITE)
                      || (q.cmd == selfprog_pkg::CMD_LOCKSET);
   assign tmr_start = (q.st == selfprog_pkg::ST_ARMED) && i_store_op && timed_cmd;

   always_comb begin
      d       = q;
      d.rdata = 8'h00;
      d.erase = 1'b0;
      d.write = 1'b0;
      d.lockw = 1'b0;
      d.bload = 1'b0;
      unique case (q.st)
         selfprog_pkg::ST_IDLE: begin
            if (wr_ctrl && i_wdata[selfprog_pkg::CTL_ENABLE]) begin
               d.cmd = i_wdata[5:0] & selfprog_pkg::CMD_MASK;
               d.win = '0;
               d.st  = selfprog_pkg::ST_ARMED;
            end
         end
         selfprog_pkg::ST_ARMED: begin
            if (i_store_op) begin
               d.pg = mif.page_sel;
               d.wd = mif.word_sel;
               d.bs = mif.byte_sel;
               if (timed_cmd) begin
                  d.erase = (q.cmd == selfprog_pkg::CMD_ERASE);
                  d.write = (q.cmd == selfprog_pkg::CMD_WRITE);
                  d.lockw = (q.cmd == selfprog_pkg::CMD_LOCKSET);
                  d.halt  = mif.target_noconc && (q.cmd != selfprog_pkg::CMD_LOCKSET);
                  // region busy on erase or write to concurrent region
                  if (!mif.target_noconc && (q.cmd != selfprog_pkg::CMD_LOCKSET)) begin
                     d.busy = 1'b1;
                  end
                  d.st = selfprog_pkg::ST_BUSY;
               end else begin
                  if (q.cmd == selfprog_pkg::CMD_REEN) begin
                     d.busy = 1'b0;
                  end
                  d.bload = (q.cmd == selfprog_pkg::CMD_LOAD);
                  d.st    = selfprog_pkg::ST_IDLE;
                  d.sts[selfprog_pkg::IRQ_DONE] = 1'b1;
               end
            end else if (i_load_op || q.win == 3'(selfprog_pkg::STORE_WINDOW_CYC - 1)) begin
               // window lapsed or lpm consumed it: enable auto-clears
               d.st = selfprog_pkg::ST_IDLE;
            end else begin
               d.win = q.win + 3'h1;
            end
         end
         selfprog_pkg::ST_BUSY: begin
            if (tmr_done) begin
               d.st   = selfprog_pkg::ST_IDLE;
               d.halt = 1'b0;
               d.sts[selfprog_pkg::IRQ_DONE] = 1'b1;
            end
         end
         default: d.st = selfprog_pkg::ST_IDLE;
      endcase
      if (d.busy && !q.busy) begin
         d.sts[selfprog_pkg::IRQ_REGION] = 1'b1;
      end

      // software clears status by writing one; set above wins only for bits that were clear
      if (i_wr && i_addr == selfprog_pkg::ADDR_STATUS) begin
         d.sts = (q.sts & ~i_wdata[selfprog_pkg::IRQ_WIDTH-1:0]) | (d.sts & ~q.sts);
      end
      if (i_wr && i_addr == selfprog_pkg::ADDR_MASK) begin
         d.msk = i_wdata[selfprog_pkg::IRQ_WIDTH-1:0];
      end

      if (i_rd) begin
         unique case (i_addr)
            selfprog_pkg::ADDR_CTRL: begin
               d.rdata[5:0] = (q.st == selfprog_pkg::ST_IDLE) ? 6'h00 : q.cmd;
               d.rdata[selfprog_pkg::CTL_BUSY] = q.busy;
            end
            selfprog_pkg::ADDR_STATUS: d.rdata = 8'(q.sts);
            selfprog_pkg::ADDR_MASK:   d.rdata = 8'(q.msk);
            selfprog_pkg::ADDR_ZPTR:   d.rdata = {q.bs, q.wd};
            selfprog_pkg::ADDR_LAYOUT: d.rdata = {4'h0, 1'(LARGE), 1'b0, i_boot_size_sel};
            selfprog_pkg::ADDR_PAGE:   d.rdata = q.pg;
            default:                   d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q    <= '0;
         q.st <= selfprog_pkg::ST_IDLE;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_rdata         = q.rdata;
   assign o_cpu_halt      = q.halt;
   assign o_fetch_blocked = q.busy && !mif.fetch_noconc;
   assign o_flash_erase   = q.erase;
   assign o_flash_write   = q.write;
   assign o_lock_write    = q.lockw;
   assign o_buf_load      = q.bload;
   assign o_page_sel      = q.pg;
   assign o_word_sel      = q.wd;
   assign o_byte_sel      = q.bs;
   assign o_boot_vector   = mif.boot_start;
   assign o_irq           = |(q.sts & q.msk);

   logic [PCW-1:0] unused_pc;
   assign unused_pc = mif.app_end[PCW-1:0] ^ mif.noconc_start[PCW-1:0] ^ mif.page_base[PCW-1:0];
endmodule

// ===== inc/selfprog_pkg.sv
// package: constants and types for the flash self-programming sequencer
package selfprog_pkg;

   // ************************************************************
   // register map (word index on the plain register port)
   // ************************************************************
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MASK   = 4'h2;
   localparam logic [3:0] ADDR_ZPTR   = 4'h3;
   localparam logic [3:0] ADDR_LAYOUT = 4'h4;
   localparam logic [3:0] ADDR_PAGE   = 4'h5;

   // control register bit positions
   localparam int CTL_ENABLE   = 0;
   localparam int CTL_ERASE    = 1;
   localparam int CTL_WRITE    = 2;
   localparam int CTL_LOCKSET  = 3;
   localparam int CTL_REENABLE = 4;
   localparam int CTL_BUSY     = 6;

   // command patterns on bits 5..0
   localparam logic [5:0] CMD_LOAD    = 6'h01;
   localparam logic [5:0] CMD_ERASE   = 6'h03;
   localparam logic [5:0] CMD_WRITE   = 6'h05;
   localparam logic [5:0] CMD_LOCKSET = 6'h09;
   localparam logic [5:0] CMD_REEN    = 6'h11;
   localparam logic [5:0] CMD_MASK    = 6'h3F;

   // interrupt status bits
   localparam int IRQ_DONE   = 0;
   localparam int IRQ_REGION = 1;
   localparam int IRQ_WIDTH  = 2;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int STORE_WINDOW_CYC = 4;
   localparam real WRITE_MIN_MS    = 3.7;
   localparam real WRITE_MAX_MS    = 4.5;

   // ************************************************************
   // memory layout constants
   // ************************************************************
   localparam int PC_BITS_SMALL   = 14;
   localparam int PC_BITS_LARGE   = 15;
   localparam int PAGE_BITS_SMALL = 6;
   localparam int PAGE_BITS_LARGE = 7;
   localparam int CONC_PAGES      = 224;
   localparam int NOCONC_PAGES    = 32;
   localparam int BOOT_PAGES_MIN  = 4;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_BUSY  = 3'b100
   } seq_state_t;

endpackage

// ===== inc/selfprog_if.sv
// interface: memory-map decode results from the address map module
`timescale 1ns/100ps
interface selfprog_if #(parameter int PCW = 15);
   logic [PCW-1:0] boot_start;
   logic [PCW-1:0] app_end;
   logic [PCW-1:0] noconc_start;
   logic [PCW-1:0] page_base;
   logic [7:0]     page_sel;
   logic [6:0]     word_sel;
   logic           byte_sel;
   logic           target_noconc;
   logic           fetch_noconc;
   modport map (output boot_start, app_end, noconc_start, page_base, page_sel, word_sel,
                byte_sel, target_noconc, fetch_noconc);
   modport seq (input boot_start, app_end, noconc_start, page_base, page_sel, word_sel,
                byte_sel, target_noconc, fetch_noconc);
endinterface

// ===== verilog/selfprog_addr_map.sv
// module: boot size, region limits and z-pointer field decode
`timescale 1ns/100ps
module selfprog_addr_map #(
   parameter bit LARGE = 1'b0
) (
   input  wire logic [1:0]  i_boot_size_sel,
   input  wire logic [15:0] i_zptr,
   input  wire logic [14:0] i_fetch_addr,
   selfprog_if.map          map
);
   localparam int PCW = LARGE ? selfprog_pkg::PC_BITS_LARGE : selfprog_pkg::PC_BITS_SMALL;
   localparam int PGB = LARGE ? selfprog_pkg::PAGE_BITS_LARGE : selfprog_pkg::PAGE_BITS_SMALL;
   localparam int NOCONC = selfprog_pkg::CONC_PAGES << PGB;

   logic [5:0]  boot_pages;
   logic [15:0] boot_words;
   logic [15:0] boot_start;
   logic [15:0] page_base;

   always_comb begin
      boot_pages = 6'(selfprog_pkg::BOOT_PAGES_MIN << (2'h3 - i_boot_size_sel));
      boot_words = 16'(boot_pages) << PGB;
      boot_start = 16'(1 << PCW) - boot_words;
      page_base  = {8'h00, i_zptr[PGB+8:PGB+1]} << PGB;
   end

   assign map.boot_start   = boot_start[14:0];
   assign map.app_end      = 15'(boot_start - 16'h0001);
   assign map.noconc_start = 15'(NOCONC);
   assign map.page_sel     = 8'(i_zptr[PCW:PGB+1]);
   assign map.page_base    = page_base[14:0];
   assign map.word_sel     = 7'(i_zptr[PGB:1]);
   assign map.byte_sel     = i_zptr[0];
   assign map.target_noconc = ({1'b0, page_base[14:0]} >= 16'(NOCONC));
   assign map.fetch_noconc  = ({1'b0, i_fetch_addr} >= 16'(NOCONC));
endmodule

// ===== verilog/selfprog_timer.sv
// module: flash write duration timer on the calibrated oscillator tick
`timescale 1ns/100ps
module selfprog_timer #(
   parameter int TICK_HZ = 1000000
) (
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   input  wire logic i_clk_en,
   input  wire logic i_osc_tick,
   input  wire logic i_start,
   output logic      o_done
);
   // minimum time rounded up in oscillator ticks
   localparam int TICKS = int'($ceil(selfprog_pkg::WRITE_MIN_MS * TICK_HZ / 1000.0));
   localparam int CW    = $clog2(TICKS + 1);

   typedef struct packed {
      logic          run;
      logic [CW-1:0] cnt;
      logic          done;
   } tmr_t;
   tmr_t q, d;

   always_comb begin
      d      = q;
      d.done = 1'b0;
      if (i_start) begin
         d.run = 1'b1;
         d.cnt = '0;
      end else if (q.run && i_osc_tick) begin
         if (q.cnt == CW'(TICKS - 1)) begin
            d.run  = 1'b0;
            d.done = 1'b1;
         end else begin
            d.cnt = q.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '0;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   assign o_done = q.done;
endmodule

// ===== verification/selfprog_seq_chk.sv
// assertions on the self-programming sequencer top ports
`timescale 1ns/100ps
module selfprog_seq_chk #(
   parameter bit LARGE   = 1'b0,
   parameter int TICK_HZ = 1000000
) (
   input wire logic        i_ref_clk,
   input wire logic        i_reset_n,
   input wire logic        i_store_op,
   input wire logic [15:0] i_zptr,
   input wire logic [14:0] i_fetch_addr,
   input wire logic [1:0]  i_boot_size_sel,
   input wire logic        o_cpu_halt,
   input wire logic        o_fetch_blocked,
   input wire logic        o_flash_erase,
   input wire logic        o_flash_write,
   input wire logic        o_lock_write,
   input wire logic        o_buf_load,
   input wire logic [7:0]  o_page_sel,
   input wire logic [6:0]  o_word_sel,
   input wire logic [14:0] o_boot_vector
);
   // ************************************************************
   // variant decode
   // ************************************************************
   wire logic [7:0]  zpage = LARGE ? i_zptr[15:8] : i_zptr[14:7];
   wire logic [6:0]  zword = LARGE ? i_zptr[7:1] : {1'b0, i_zptr[6:1]};
   wire logic [6:0]  wsel  = LARGE ? o_word_sel : {1'b0, o_word_sel[5:0]};
   // top of flash wraps to zero in the large variant
   wire logic [14:0] top   = LARGE ? 15'h0000 : 15'h4000;
   wire logic [14:0] unit  = LARGE ? 15'h0200 : 15'h0100;
   wire logic [14:0] lim   = LARGE ? 15'h7000 : 15'h3800;
   wire logic        cmd   = o_flash_write | o_flash_erase | o_lock_write | o_buf_load;
   wire logic        pgop  = o_flash_write | o_flash_erase;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   // ************************************************************
   // assertions
   // ************************************************************
   chk_write_single: assert property (o_flash_write |=> !o_flash_write)
      else $error("page write pulse longer than one cycle");
   chk_cmd_cause: assert property (cmd |-> $past(i_store_op))
      else $error("command pulse without store one cycle before");
   chk_one_cmd: assert property (
      $onehot0({o_flash_write, o_flash_erase, o_lock_write, o_buf_load}))
      else $error("more than one command pulse");
   chk_page_capture: assert property (pgop |-> o_page_sel == $past(zpage))
      else $error("page select not taken from z pointer");
   chk_word_capture: assert property (o_buf_load |-> wsel == $past(zword))
      else $error("word select not taken from z pointer");
   chk_halt_region: assert property ($rose(o_cpu_halt) |-> pgop && o_page_sel >= 8'hE0)
      else $error("halt without write to top region");
   chk_conc_run: assert property (pgop && o_page_sel < 8'hE0 |-> !o_cpu_halt)
      else $error("cpu halted for concurrent region write");
   chk_fetch_limit: assert property (o_fetch_blocked |-> i_fetch_addr < lim)
      else $error("fetch blocked inside top region");
   chk_boot_vector: assert property (o_boot_vector == top - (unit << ~i_boot_size_sel))
      else $error("boot vector wrong for size code");

   cover property (o_flash_write);
   cover property (o_flash_erase && o_cpu_halt);
   cover property (o_buf_load);
   cover property (o_fetch_blocked);
endmodule

bind selfprog_seq selfprog_seq_chk #(.LARGE(LARGE), .TICK_HZ(TICK_HZ)) selfprog_seq_chk_i (
   .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_store_op(i_store_op), .i_zptr(i_zptr),
   .i_fetch_addr(i_fetch_addr), .i_boot_size_sel(i_boot_size_sel), .o_cpu_halt(o_cpu_halt),
   .o_fetch_blocked(o_fetch_blocked), .o_flash_erase(o_flash_erase),
   .o_flash_write(o_flash_write), .o_lock_write(o_lock_write), .o_buf_load(o_buf_load),
   .o_page_sel(o_page_sel), .o_word_sel(o_word_sel), .o_boot_vector(o_boot_vector));

// ===== verification/selfprog_cpu_model.sv
// cpu core model issuing self-programming sequences and oscillator ticks
`timescale 1ns/100ps
module selfprog_cpu_model (
   input  wire logic        i_ref_clk,
   input  wire logic [7:0]  i_rdata,
   output logic      [3:0]  o_addr = 4'h0,
   output logic      [7:0]  o_wdata = 8'h00,
   output logic             o_wr = 1'b0,
   output logic             o_rd = 1'b0,
   output logic             o_chk = 1'b0,
   output logic             o_store_op = 1'b0,
   output logic      [15:0] o_zptr = 16'h0000,
   output logic             o_osc_tick = 1'b0
);
   int tick_cnt_q = 0;

   // oscillator ticks, far slower than cpu clock
   always @(posedge i_ref_clk) begin
      tick_cnt_q <= (tick_cnt_q == 49) ? 0 : tick_cnt_q + 1;
      o_osc_tick <= (tick_cnt_q == 49);
   end

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_ref_clk);
      o_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic c);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      o_chk <= c;
      @(posedge i_ref_clk);
      o_rd <= 1'b0;
      o_chk <= 1'b0;
   endtask

   // poll command bits until previous command is over
   task automatic poll_idle();
      logic [7:0] d;
      d = 8'hFF;
      for (int n = 0; n < 2000 && d[5:0] != 6'h00; n++) begin
         reg_rd(selfprog_pkg::ADDR_CTRL, 1'b0);
         @(posedge i_ref_clk);
         d = i_rdata;
      end
   endtask

   // store follows command after gap cycles, z held throughout
   task automatic spm(input logic [5:0] cmd, input logic [15:0] z, input int gap);
      poll_idle();
      o_zptr <= z;
      reg_wr(selfprog_pkg::ADDR_CTRL, {2'b00, cmd});
      repeat (gap - 1) @(posedge i_ref_clk);
      o_store_op <= 1'b1;
      @(posedge i_ref_clk);
      o_store_op <= 1'b0;
   endtask
endmodule

// ===== verification/test_boot_flash_self_program_map.sv
// testbench for the flash self-programming sequencer
`timescale 1ns/100ps
module test_boot_flash_self_program_map;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ee_busy = 1'b0;
   logic [1:0]  bsz = 2'h0;
   logic [14:0] fetch = 15'h0000;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, pg;
   logic        wr, rd, chk, store, tick, halt, blocked, erase, fwrite, lockw, bufld, irq;
   logic        chk_d = 1'b0;
   logic        cke = 1'b1;
   logic        lop = 1'b0;
   logic        bsel;
   logic [15:0] zptr;
   logic [7:0]  psel;
   logic [6:0]  wsel;
   logic [5:0]  wd;
   logic [14:0] bvec;
   logic [7:0]  exp_q[$];
   int          bad_count = 0;
   int          cmp_count = 0;
   int          ticks = 0;
   int          pw = 0;

   initial forever #2 clk = ~clk;

   selfprog_cpu_model cpu_i (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .o_chk(chk), .o_store_op(store), .o_zptr(zptr), .o_osc_tick(tick));

   // short tick rate so one timed command is four ticks
   selfprog_seq #(.LARGE(1'b0), .TICK_HZ(1000)) selfprog_seq_i (.i_ref_clk(clk),
      .i_reset_n(rst_n), .i_clk_en(cke), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_store_op(store), .i_load_op(lop), .i_zptr(zptr),
      .i_fetch_addr(fetch), .i_boot_size_sel(bsz), .i_eeprom_write_strobe(ee_busy),
      .i_osc_tick(tick), .o_cpu_halt(halt), .o_fetch_blocked(blocked), .o_flash_erase(erase),
      .o_flash_write(fwrite), .o_lock_write(lockw), .o_buf_load(bufld), .o_page_sel(psel),
      .o_word_sel(wsel), .o_byte_sel(bsel), .o_boot_vector(bvec), .o_irq(irq));

   // ************************************************************
   // monitors
   // ************************************************************
   // weighted pulse sum: erase 1, write 2, lock 4, load 8
   always @(posedge clk) begin
      ticks <= ticks + int'(tick);
      pw <= pw + int'({bufld, lockw, fwrite, erase});
      chk_d <= chk;
      if (chk_d)
         check(16'(rdata), 16'(exp_q.pop_front()));
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      cpu_i.reg_rd(a, 1'b1);
   endtask

   task automatic done(input int t0);
      cpu_i.poll_idle();
      check(16'(ticks - t0 >= 4 && ticks - t0 <= 5), 16'h0001);
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      int t0;
      int p0;
      void'($urandom(15));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         bsz <= 2'(s);
         @(posedge clk);
         #1;
         check(16'(bvec), 16'(15'h4000 - (15'h0800 >> s)));
         rd_exp(selfprog_pkg::ADDR_LAYOUT, 8'(s));
      end
      $display("test boot size done");
      // page write low region; word and byte bits zero, eeprom idle
      pg = 8'($urandom_range(0, 223));
      fetch <= 15'h0100;
      p0 = pw;
      cpu_i.reg_wr(selfprog_pkg::ADDR_MASK, 8'h00);
      cpu_i.poll_idle();
      t0 = ticks;
      cpu_i.spm(selfprog_pkg::CMD_WRITE, {1'b0, pg, 7'h00}, 1 + $urandom_range(0, 3));
      #1;
      check(16'(psel), 16'(pg));
      check(16'({halt, blocked}), 16'h0001);
      done(t0);
      check(16'(irq), 16'h0000);
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h40);
      rd_exp(selfprog_pkg::ADDR_STATUS, 8'h03);
      cpu_i.reg_wr(selfprog_pkg::ADDR_MASK, 8'h03);
      #1;
      check(16'(irq), 16'h0001);
      cpu_i.reg_wr(selfprog_pkg::ADDR_STATUS, 8'h03);
      #1;
      check(16'(irq), 16'h0000);
      cpu_i.spm(selfprog_pkg::CMD_REEN, 16'h0000, 2);
      cpu_i.poll_idle();
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h00);
      check(16'(pw - p0), 16'h0002);
      $display("test concurrent write done");
      pg = 8'hE0 + 8'($urandom_range(0, 31));
      fetch <= 15'h3900;
      p0 = pw;
      t0 = ticks;
      cpu_i.spm(selfprog_pkg::CMD_ERASE, {1'b0, pg, 7'h00}, 1 + $urandom_range(0, 3));
      #1;
      check(16'({halt, blocked}), 16'h0002);
      done(t0);
      check(16'(halt), 16'h0000);
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h00);
      t0 = ticks;
      cpu_i.spm(selfprog_pkg::CMD_LOCKSET, 16'h0001, 4);
      #1;
      check(16'(halt), 16'h0000);
      done(t0);
      check(16'(pw - p0), 16'h0005);
      $display("test top erase and lock done");
      // store one cycle late, then command during eeprom write
      p0 = pw;
      cpu_i.spm(selfprog_pkg::CMD_WRITE, 16'h0000, 5);
      repeat (4) @(posedge clk);
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h00);
      // eeprom write in progress blocks the command
      ee_busy <= 1'b1;
      cpu_i.reg_wr(selfprog_pkg::ADDR_CTRL, 8'h05);
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h00);
      ee_busy <= 1'b0;
      // load op consumes the store window, so the armed command is gone
      cpu_i.reg_wr(selfprog_pkg::ADDR_CTRL, 8'h01);
      lop <= 1'b1;
      @(posedge clk);
      lop <= 1'b0;
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h00);
      // clock enable low freezes the window; command still armed after
      cpu_i.reg_wr(selfprog_pkg::ADDR_CTRL, 8'h01);
      cke <= 1'b0;
      repeat (8) @(posedge clk);
      cke <= 1'b1;
      rd_exp(selfprog_pkg::ADDR_CTRL, 8'h01);
      wd = 6'($urandom_range(0, 63));
      cpu_i.spm(selfprog_pkg::CMD_LOAD, {1'b0, pg, wd, 1'b0}, 4);
      #1;
      check(16'(wsel[5:0]), 16'(wd));
      check(16'(bsel), 16'h0000);
      rd_exp(selfprog_pkg::ADDR_ZPTR, {2'b00, wd});
      rd_exp(selfprog_pkg::ADDR_PAGE, pg);
      cpu_i.poll_idle();
      check(16'(pw - p0), 16'h0008);
      $display("test refusals and buffer load done");
      summarize();
   end

   // run takes about 750 cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
endmodule
